// >>> cca_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"

module cca_top #(
    parameter int TW   = 16,
    parameter int NPIN = `CCA_NPIN
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic            aux_timer_six_ovf_i,
    input  wire logic            ext_cnt_i,
    input  wire logic [NPIN-1:0] cap_pin_i,
    output logic      [NPIN-1:0] cmp_pin_o,
    output logic      [NPIN-1:0] cmp_pin_oe_o,
    output logic                 irq_o
);
    localparam int NCH = `CCA_NCH;
    localparam int NPR = `CCA_NPAIR;
    if (TW < 2 || TW > 31) begin : g_bad_tw
        $error("timer width must lie between 2 and 31");
    end
    if (NPIN < 1 || NPIN > `CCA_NPIN) begin : g_bad_npin
        $error("pin count must lie between 1 and 12");
    end

    // merge write data into a word under the byte enables
    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    cca_tmr_if #(.TW(TW)) tif [2] ();
    logic [31:0]         ctrl_q;
    logic [31:0]         ctrl_d;
    logic [TW-1:0]       rel_q [2];
    logic [TW-1:0]       rel_d [2];
    logic [NCH-1:0]      mask_q;
    logic [NCH-1:0]      mask_d;
    logic [NCH-1:0]      stat_q;
    logic [NCH-1:0]      stat_d;
    logic [NPR-1:0]      dbl_q;
    logic [NPR-1:0]      dbl_d;
    logic [31:0]         cfg_q [NCH];
    logic [31:0]         cfg_d [NCH];
    logic [TW-1:0]       chv_q [NCH];
    logic                ack_q;
    logic                ack_d;
    logic [31:0]         rdat_q;
    logic [31:0]         rdat_d;
    logic                irq_q;
    logic                irq_d;
    logic [1:0]          tld;
    logic [NCH-1:0]      val_we;
    logic [NCH-1:0]      cfg_we;
    logic [NCH-1:0]      evt;
    logic [NCH-1:0]      cmp_evt;
    logic [`CCA_PRE_BITS-1:0] pre_q;
    logic [`CCA_PRE_BITS-1:0] pre_d;
    logic [2:0]          ext_q;
    logic [2:0]          ext_d;
    logic                wr;
    logic [5:0]          widx;
    logic [3:0]          cidx;
    wire logic [NCH-1:0] cap_all = NCH'(cap_pin_i);  // channels without a pin see a quiet 0

    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign widx = wb_adr_i[7:2];
    assign cidx = wb_adr_i[5:2];

    // bus slave, control registers and interrupt status
    always_comb begin
        ctrl_d = ctrl_q;
        rel_d  = rel_q;
        mask_d = mask_q;
        dbl_d  = dbl_q;
        cfg_d  = cfg_q;
        stat_d = stat_q;
        tld    = 2'b00;
        val_we = '0;
        cfg_we = '0;
        rdat_d = 32'h0000_0000;
        ack_d  = wb_cyc_i && wb_stb_i && !ack_q;   // one wait state, then drop
        if (wr) begin
            case ({widx, 2'b00})
                `CCA_ADR_CTRL:     ctrl_d = wmask(ctrl_q, wb_dat_i, wb_sel_i) & `CCA_CTRL_WMASK;
                `CCA_ADR_TVAL_A:   tld[0] = 1'b1;
                `CCA_ADR_TVAL_B:   tld[1] = 1'b1;
                `CCA_ADR_RELOAD_A: rel_d[0] = TW'(wmask(32'(rel_q[0]), wb_dat_i, wb_sel_i));
                `CCA_ADR_RELOAD_B: rel_d[1] = TW'(wmask(32'(rel_q[1]), wb_dat_i, wb_sel_i));
                `CCA_ADR_MASK:     mask_d = NCH'(wmask(32'(mask_q), wb_dat_i, wb_sel_i));
                `CCA_ADR_DOUBLE:   dbl_d = NPR'(wmask(32'(dbl_q), wb_dat_i, wb_sel_i));
                default: begin
                    if (widx[5:4] == 2'b01) begin
                        cfg_we[cidx] = 1'b1;
                        cfg_d[cidx]  = wmask(cfg_q[cidx], wb_dat_i, wb_sel_i)
                                       & `CCA_CFG_WMASK;
                    end else if (widx[5:4] == 2'b10) begin
                        val_we[cidx] = 1'b1;
                    end
                end
            endcase
        end
        // write one to clear; a new event in the same cycle still sets
        if (wr && {widx, 2'b00} == `CCA_ADR_STATUS) begin
            stat_d = stat_q & ~NCH'(wmask(32'h0000_0000, wb_dat_i, wb_sel_i));
        end
        stat_d = stat_d | evt;
        irq_d  = |(stat_d & mask_d);
        case ({widx, 2'b00})
            `CCA_ADR_CTRL:     rdat_d = ctrl_q;
            `CCA_ADR_TVAL_A:   rdat_d = 32'(tif[0].val);
            `CCA_ADR_TVAL_B:   rdat_d = 32'(tif[1].val);
            `CCA_ADR_RELOAD_A: rdat_d = 32'(rel_q[0]);
            `CCA_ADR_RELOAD_B: rdat_d = 32'(rel_q[1]);
            `CCA_ADR_STATUS:   rdat_d = 32'(stat_q);
            `CCA_ADR_MASK:     rdat_d = 32'(mask_q);
            `CCA_ADR_DOUBLE:   rdat_d = 32'(dbl_q);
            default:           rdat_d = widx[5:4] == 2'b01 ? cfg_q[cidx] :
                                        widx[5:4] == 2'b10 ? 32'(chv_q[cidx]) : 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `CCA_CTRL_RST;
            rel_q  <= '{default: '0};
            mask_q <= `CCA_MASK_RST;
            dbl_q  <= `CCA_DOUBLE_RST;
            cfg_q  <= '{default: `CCA_CFG_RST};
            stat_q <= '0;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
            irq_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rel_q  <= rel_d;
            mask_q <= mask_d;
            dbl_q  <= dbl_d;
            cfg_q  <= cfg_d;
            stat_q <= stat_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
            irq_q  <= irq_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o    = irq_q;

    // free prescaler and external count synchroniser
    always_comb begin
        pre_d = pre_q + `CCA_PRE_BITS'(1);
        ext_d = {ext_q[1:0], ext_cnt_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= '0;
            ext_q <= 3'b000;
        end else begin
            pre_q <= pre_d;
            ext_q <= ext_d;
        end
    end

    // count source selection and timers
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        logic [2:0] src;
        logic       raw;
        logic       stag_ok;
        assign src     = ctrl_q[(t == 0 ? `CCA_CTRL_SRC_A : `CCA_CTRL_SRC_B) +: 3];
        // staggered mode lets a timer step only once per eight clocks
        assign stag_ok = !ctrl_q[`CCA_CTRL_STAG] ||
                         (pre_q[2:0] == 3'(`CCA_STAG_DIV - 1));
        always_comb begin
            case (src)
                cca_pkg::CCA_SRC_CLK:    raw = 1'b1;
                cca_pkg::CCA_SRC_DIV8:   raw = &pre_q[2:0];
                cca_pkg::CCA_SRC_DIV64:  raw = &pre_q[5:0];
                cca_pkg::CCA_SRC_DIV512: raw = &pre_q;
                cca_pkg::CCA_SRC_AUX:    raw = aux_timer_six_ovf_i;
                cca_pkg::CCA_SRC_EXT:    raw = (t == 0) && ext_q[1] && !ext_q[2];
                default:                 raw = 1'b0;
            endcase
        end
        assign tif[t].tick   = raw && stag_ok;
        assign tif[t].run    = ctrl_q[t == 0 ? `CCA_CTRL_RUN_A : `CCA_CTRL_RUN_B];
        assign tif[t].ld     = tld[t];
        assign tif[t].ld_val = TW'(wmask(32'(tif[t].val), wb_dat_i, wb_sel_i));
        assign tif[t].rel    = rel_q[t];
        cca_timer #(.TW(TW)) u_tmr (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .tif   (tif[t])
        );
    end

    // per channel capture/compare logic
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        cca_pkg::cca_mode_t mode;
        logic          tsel;
        logic [TW-1:0] tval;
        logic          tupd;
        logic          tovf;
        logic          match;
        logic          cap_evt;
        logic          edge_r;
        logic          edge_f;
        logic [2:0]    syn_q;
        logic [2:0]    syn_d;
        logic [TW-1:0] chv_d;
        logic          prd_q;
        logic          prd_d;
        logic          one_q;
        logic          one_d;

        assign mode = cca_pkg::cca_mode_t'(cfg_q[n][`CCA_CFG_MODE +: 3]);
        assign tsel = cfg_q[n][`CCA_CFG_TSEL];
        assign tval = tsel ? tif[1].val : tif[0].val;
        assign tupd = tsel ? tif[1].upd : tif[0].upd;
        assign tovf = tsel ? tif[1].ovf : tif[0].ovf;
        // only the second and third stages feed the edge detector
        assign edge_r = syn_q[1] && !syn_q[2];
        assign edge_f = !syn_q[1] && syn_q[2];
        assign cap_evt = (mode == cca_pkg::CCA_CAP) &&
                         ((cfg_q[n][`CCA_CFG_EDGE] && edge_r) ||
                          (cfg_q[n][`CCA_CFG_EDGE + 1] && edge_f));
        assign match = cfg_q[n][`CCA_CFG_MODE + 2] && tupd &&
                       (tval == chv_q[n]);

        always_comb begin
            syn_d = {syn_q[1:0], cap_all[n]};
            cmp_evt[n] = match &&
                         !(prd_q && (mode == cca_pkg::CCA_CMP2 ||
                                     mode == cca_pkg::CCA_CMP3)) &&
                         !(one_q && cfg_q[n][`CCA_CFG_SINGLE]);
            evt[n] = cmp_evt[n] || cap_evt;
            // the period latch re-arms on overflow; in CCA_CMP2/CCA_CMP3 a match in that cycle is masked while it is set, so it clears
            prd_d = cmp_evt[n] || (prd_q && !tovf);
            one_d = evt[n] || (one_q && !cfg_we[n] && !val_we[n]);
            chv_d = chv_q[n];
            if (cap_evt) begin
                chv_d = tval;
            end else if (val_we[n]) begin
                chv_d = TW'(wmask(32'(chv_q[n]), wb_dat_i, wb_sel_i));
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                syn_q   <= 3'b000;
                chv_q[n] <= '0;
                prd_q   <= 1'b0;
                one_q   <= 1'b0;
            end else begin
                syn_q   <= syn_d;
                chv_q[n] <= chv_d;
                prd_q   <= prd_d;
                one_q   <= one_d;
            end
        end

        // compare output pin for the channels that own one
        if (n < NPIN) begin : g_pin
            logic pin_q;
            logic pin_d;
            logic oe_q;
            logic oe_d;
            logic dbl;
            logic tog;
            // pins above the pair range never share; the modulo keeps indices in range
            assign dbl = (n < NPR) && dbl_q[n % NPR];
            assign tog = dbl && (cmp_evt[n] || cmp_evt[(n + NPR) % NCH]);
            always_comb begin
                pin_d = pin_q;
                if (mode == cca_pkg::CCA_CMP3 && cmp_evt[n]) begin
                    pin_d = 1'b1;
                end else if (mode == cca_pkg::CCA_CMP3 && tovf) begin
                    pin_d = 1'b0;
                end else if (tog || (!dbl && mode == cca_pkg::CCA_CMP1 && cmp_evt[n])) begin
                    pin_d = !pin_q;
                end
                oe_d = dbl || mode == cca_pkg::CCA_CMP1 || mode == cca_pkg::CCA_CMP3;
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_q <= 1'b0;
                    oe_q  <= 1'b0;
                end else begin
                    pin_q <= pin_d;
                    oe_q  <= oe_d;
                end
            end
            assign cmp_pin_o[n]    = pin_q;
            assign cmp_pin_oe_o[n] = oe_q;
        end
    end
endmodule

`default_nettype wire

// >>> cca_map.svh
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// register byte offsets, one aligned 32-bit word each
`define CCA_ADR_CTRL     8'h00
`define CCA_ADR_TVAL_A   8'h04
`define CCA_ADR_TVAL_B   8'h08
`define CCA_ADR_RELOAD_A 8'h0c
`define CCA_ADR_RELOAD_B 8'h10
`define CCA_ADR_STATUS   8'h14
`define CCA_ADR_MASK     8'h18
`define CCA_ADR_DOUBLE   8'h1c
`define CCA_ADR_CFG_BASE 8'h40
`define CCA_ADR_VAL_BASE 8'h80

// control register fields
`define CCA_CTRL_RUN_A   0
`define CCA_CTRL_RUN_B   1
`define CCA_CTRL_STAG    2
`define CCA_CTRL_SRC_A   4
`define CCA_CTRL_SRC_B   8
`define CCA_CTRL_WMASK   32'h0000_0777

// channel configuration fields
`define CCA_CFG_MODE     0
`define CCA_CFG_TSEL     3
`define CCA_CFG_EDGE     4
`define CCA_CFG_SINGLE   6
`define CCA_CFG_WMASK    32'h0000_007f

// reset values
`define CCA_CTRL_RST     32'h0000_0000
`define CCA_CFG_RST      32'h0000_0000
`define CCA_MASK_RST     16'h0000
`define CCA_DOUBLE_RST   8'h00

// channel count, pairing distance and timing counts
`define CCA_NCH          16
`define CCA_NPIN         12
`define CCA_NPAIR        8
`define CCA_STAG_DIV     8
`define CCA_PRE_BITS     9

`endif

// >>> cca_pkg.sv
package cca_pkg;

    // channel mode field
    typedef enum logic [2:0] {
        CCA_OFF  = 3'h0,
        CCA_CAP  = 3'h1,
        CCA_CMP0 = 3'h4,
        CCA_CMP1 = 3'h5,
        CCA_CMP2 = 3'h6,
        CCA_CMP3 = 3'h7
    } cca_mode_t;

    // timer count source field
    typedef enum logic [2:0] {
        CCA_SRC_CLK    = 3'h0,
        CCA_SRC_DIV8   = 3'h1,
        CCA_SRC_DIV64  = 3'h2,
        CCA_SRC_DIV512 = 3'h3,
        CCA_SRC_AUX    = 3'h4,
        CCA_SRC_EXT    = 3'h5
    } cca_src_t;

endpackage

// >>> cca_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cca_tmr_if #(
    parameter int TW = 16
);
    logic          tick;
    logic          run;
    logic          ld;
    logic [TW-1:0] ld_val;
    logic [TW-1:0] rel;
    logic [TW-1:0] val;
    logic          upd;
    logic          ovf;

    modport ctl (output tick, output run, output ld, output ld_val, output rel,
                 input val, input upd, input ovf);
    modport tmr (input tick, input run, input ld, input ld_val, input rel,
                 output val, output upd, output ovf);
endinterface

`default_nettype wire

// >>> cca_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cca_timer #(
    parameter int TW = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    cca_tmr_if.tmr    tif
);
    logic [TW-1:0] val_q;
    logic [TW-1:0] val_d;
    logic          upd_q;
    logic          upd_d;
    logic          ovf_q;
    logic          ovf_d;

    // count up; a software load beats a tick in the same cycle
    always_comb begin
        val_d = val_q;
        upd_d = 1'b0;
        ovf_d = 1'b0;
        if (tif.ld) begin
            val_d = tif.ld_val;
        end else if (tif.run && tif.tick) begin
            upd_d = 1'b1;
            if (val_q == {TW{1'b1}}) begin
                val_d = tif.rel;           // restart from the reload value
                ovf_d = 1'b1;
            end else begin
                val_d = val_q + TW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_q <= '0;
            upd_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            val_q <= val_d;
            upd_q <= upd_d;
            ovf_q <= ovf_d;
        end
    end

    assign tif.val = val_q;
    assign tif.upd = upd_q;
    assign tif.ovf = ovf_q;
endmodule

`default_nettype wire

// >>> cca_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"

module cca_top_monitor #(
    parameter int TW   = 16,
    parameter int NPIN = 12
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    input  wire logic [31:0]     wb_dat_o,
    input  wire logic            wb_ack_o,
    input  wire logic            aux_timer_six_ovf_i,
    input  wire logic            ext_cnt_i,
    input  wire logic [NPIN-1:0] cap_pin_i,
    input  wire logic [NPIN-1:0] cmp_pin_o,
    input  wire logic [NPIN-1:0] cmp_pin_oe_o,
    input  wire logic            irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic        req;
    logic        wr;
    logic [15:0] rel_a_d;
    logic [15:0] rel_a_q;
    logic [15:0] mask_d;
    logic [15:0] mask_q;

    function automatic logic [15:0] lanes(input logic [15:0] old);
        return {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : old[7:0]};
    endfunction

    // a request is taken only at an edge where ack is still low
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;

    // shadows of reload a and mask, kept so reads and irq can be judged
    always_comb begin
        rel_a_d = rel_a_q;
        mask_d  = mask_q;
        if (wr && {wb_adr_i[7:2], 2'h0} == `CCA_ADR_RELOAD_A) begin
            rel_a_d = lanes(rel_a_q);
        end
        if (wr && {wb_adr_i[7:2], 2'h0} == `CCA_ADR_MASK) begin
            mask_d = lanes(mask_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rel_a_q <= 16'h0;
            mask_q  <= 16'h0;
        end else begin
            rel_a_q <= rel_a_d;
            mask_q  <= mask_d;
        end
    end

    property p_ack_next;
        req |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i == 8'hfc |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_reload_rd;
        wb_ack_o && !wb_we_i && {wb_adr_i[7:2], 2'h0} == `CCA_ADR_RELOAD_A
            |-> wb_dat_o[15:0] == rel_a_q;
    endproperty
    a_reload_rd: assert property (p_reload_rd) else $error("reload read mismatch");

    property p_irq_masked;
        mask_q == 16'h0 && mask_d == 16'h0 |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");

    // status is sticky, so only a write may drop the interrupt
    property p_irq_hold;
        irq_o && !wr && !$past(wr) |=> irq_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");

    property p_oe_cause;
        !$past(rst_i) && cmp_pin_oe_o != $past(cmp_pin_oe_o) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
endmodule

bind cca_top cca_top_monitor #(.TW(TW), .NPIN(NPIN)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_timer_six_ovf_i(aux_timer_six_ovf_i),
    .ext_cnt_i(ext_cnt_i), .cap_pin_i(cap_pin_i), .cmp_pin_o(cmp_pin_o),
    .cmp_pin_oe_o(cmp_pin_oe_o), .irq_o(irq_o));

`default_nettype wire

// >>> cca_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module cca_pin_model (
    input  wire logic        clk_i,
    input  wire logic [11:0] cap_lvl_i,
    input  wire logic        aux_req_i,
    input  wire logic        ext_req_i,
    output logic      [11:0] cap_pin_o,
    output logic             aux_ovf_o,
    output logic             ext_cnt_o
);
    logic [1:0] ext_q;

    initial begin
        cap_pin_o = 12'h0;
        aux_ovf_o = 1'h0;
        ext_cnt_o = 1'h0;
        ext_q     = 2'h0;
    end

    // lines move just after an edge, as a real far side would
    always @(posedge clk_i) begin
        cap_pin_o <= cap_lvl_i;
        aux_ovf_o <= aux_req_i; // single-cycle overflow pulse
        ext_q     <= ext_req_i ? 2'h3 : (ext_q == 2'h0 ? 2'h0 : ext_q - 2'h1);
        ext_cnt_o <= ext_req_i || ext_q > 2'h1; // high three cycles to pass the synchroniser
    end
endmodule

`default_nettype wire

// >>> cca_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module cca_top_tb;
    logic        clk_i   = 1'h0;
    logic        rst_i   = 1'h1;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_we_i  = 1'h0;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic        wb_ack_o;
    logic        aux_ovf;
    logic        ext_cnt;
    logic        irq_o;
    logic        aux_req = 1'h0;
    logic        ext_req = 1'h0;
    logic [11:0] cap_lvl = 12'h0;
    logic [11:0] cap_pin;
    logic [11:0] cmp_pin_o;
    logic [11:0] cmp_pin_oe_o;
    logic [15:0] r;
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 31366;
    int          n;
    int          e;
    int          k;

    initial forever #5 clk_i = ~clk_i;

    cca_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_timer_six_ovf_i(aux_ovf),
        .ext_cnt_i(ext_cnt), .cap_pin_i(cap_pin), .cmp_pin_o(cmp_pin_o),
        .cmp_pin_oe_o(cmp_pin_oe_o), .irq_o(irq_o));

    cca_pin_model u_pins (
        .clk_i(clk_i), .cap_lvl_i(cap_lvl), .aux_req_i(aux_req), .ext_req_i(ext_req),
        .cap_pin_o(cap_pin), .aux_ovf_o(aux_ovf), .ext_cnt_o(ext_cnt));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        int i;
        i = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, w, s, a, d};
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'h1 && i < 50);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= 7'h0;
        if (wb_ack_o !== 1'h1) begin
            n_fail++;
            print_verdict();
        end
    endtask

    // cycles until compare pin k changes, capped at lim
    task automatic wait_pin(input int k, input int lim, output int cnt);
        logic v;
        v = cmp_pin_o[k];
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while (cmp_pin_o[k] === v && cnt < lim);
    endtask

    task automatic pulse(input logic ext);
        @(posedge clk_i);
        {ext_req, aux_req} <= {ext, ~ext};
        @(posedge clk_i);
        {ext_req, aux_req} <= 2'h0;
        repeat (8) @(posedge clk_i);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        // reset values and an unmapped word
        wb(0, `CCA_ADR_CTRL, 0);
        `CHK("ctrl", 32'h0, rd)
        wb(0, 8'hfc, 0);
        `CHK("unmapped", 32'h0, rd)
        wb(1, `CCA_ADR_RELOAD_A, 32'hffc0);
        wb(0, `CCA_ADR_RELOAD_A, 0);
        `CHK("reload_a", 32'hffc0, rd)
        // toggle period: plain, staggered, then single event
        wb(1, `CCA_ADR_VAL_BASE, 32'hffe0);
        for (e = 0; e < 3; e++) begin
            wb(1, `CCA_ADR_CTRL, 0);
            wb(1, `CCA_ADR_TVAL_A, 32'hffc0);
            wb(1, `CCA_ADR_CFG_BASE, e == 2 ? 32'h45 : 32'h05);
            wb(1, `CCA_ADR_CTRL, e == 1 ? 32'h5 : 32'h1);
            wait_pin(0, 1000, n);
            `CHK("oe0", 1'h1, cmp_pin_oe_o[0])
            wait_pin(0, 1000, n);
            `CHK("period", e == 0 ? 64 : (e == 1 ? 512 : 1000), n)
        end
        // double mode on pair 0, prescaler /8: channels 0 and 8 both toggle pin 0
        wb(1, `CCA_ADR_CTRL, 0);
        wb(1, `CCA_ADR_TVAL_A, 32'hffc0);
        wb(1, `CCA_ADR_VAL_BASE + 8'h20, 32'hffd0);
        wb(1, `CCA_ADR_CFG_BASE + 8'h20, 32'h04);
        wb(1, `CCA_ADR_CFG_BASE, 32'h04);
        wb(1, `CCA_ADR_DOUBLE, 32'h1);
        wb(1, `CCA_ADR_CTRL, 32'h11);
        wait_pin(0, 1000, n);
        wait_pin(0, 1000, n);
        `CHK("dbl_first", 128, n)
        wait_pin(0, 1000, n);
        `CHK("dbl_second", 384, n)
        // byte lanes: only byte 1 of the reload word is written
        wb(1, `CCA_ADR_RELOAD_B, 32'h1234, 4'h2);
        wb(0, `CCA_ADR_RELOAD_B, 0);
        `CHK("reload_lane", 32'h1200, rd)
        // mode 3 on timer b: set at match, cleared at overflow
        wb(1, `CCA_ADR_CTRL, 0);
        wb(1, `CCA_ADR_RELOAD_B, 32'hff00);
        wb(1, `CCA_ADR_TVAL_B, 32'hff00);
        wb(1, `CCA_ADR_VAL_BASE + 8'h04, 32'hff80);
        wb(1, `CCA_ADR_CFG_BASE + 8'h04, 32'h0f);
        wb(1, `CCA_ADR_CTRL, 32'h2);
        wait_pin(1, 1000, n);
        if (cmp_pin_o[1] !== 1'h1) wait_pin(1, 1000, n);
        wait_pin(1, 1000, n);
        `CHK("mode3_high", 128, n)
        wait_pin(1, 1000, n);
        `CHK("mode3_low", 128, n)
        // mode 0 fires again in one period, mode 2 does not
        wb(1, `CCA_ADR_CTRL, 32'h51);
        for (k = 2; k < 4; k++) begin
            wb(1, `CCA_ADR_VAL_BASE + 8'(4 * k), 32'h10);
            wb(1, `CCA_ADR_CFG_BASE + 8'(4 * k), k == 2 ? 32'h4 : 32'h6);
        end
        wb(1, `CCA_ADR_MASK, 32'h4);
        for (e = 0; e < 2; e++) begin
            wb(1, `CCA_ADR_STATUS, 32'hffff);
            wb(1, `CCA_ADR_TVAL_A, 32'h0f);
            pulse(1);
            wb(0, `CCA_ADR_STATUS, 0);
            `CHK("status", e == 0 ? 32'hc : 32'h4, rd)
            `CHK("irq", 1'h1, irq_o)
        end
        wb(0, `CCA_ADR_TVAL_A, 0);
        `CHK("ext_count", 32'h10, rd)
        wb(1, `CCA_ADR_MASK, 0);
        repeat (2) @(posedge clk_i);
        `CHK("irq_masked", 1'h0, irq_o)
        // capture on timer b for each edge selection, rise then fall
        wb(1, `CCA_ADR_CTRL, 0);
        for (e = 1; e < 4; e++) begin
            wb(1, `CCA_ADR_CFG_BASE + 8'h10, 32'h9 | (e << 4));
            for (n = 0; n < 2; n++) begin
                r = 16'($random(seed));
                wb(1, `CCA_ADR_TVAL_B, {16'h0, r});
                wb(1, `CCA_ADR_STATUS, 32'hffff);
                cap_lvl[4] <= ~cap_lvl[4];
                repeat (8) @(posedge clk_i);
                wb(0, `CCA_ADR_STATUS, 0);
                `CHK("cap_flag", e[n], rd[4])
                wb(0, `CCA_ADR_VAL_BASE + 8'h10, 0);
                if (e[n]) `CHK("cap_value", r, rd[15:0])
            end
        end
        // timer b counts auxiliary overflow pulses
        wb(1, `CCA_ADR_CTRL, 32'h402);
        wb(1, `CCA_ADR_TVAL_B, 32'h1000);
        k = 1 + ($random(seed) & 7);
        for (e = 0; e < k; e++) pulse(0);
        wb(0, `CCA_ADR_TVAL_B, 0);
        `CHK("aux_count", 32'h1000 + k, rd)
        print_verdict();
    end
endmodule

`default_nettype wire
